/* shared/cdp_params.svh */
`ifndef CDP_PARAMS_SVH
`define CDP_PARAMS_SVH
// Reset value of the working registers
`define CDP_REG_RST 16'h0000
// Reset value of the stack pointer
`define CDP_SP_RST 16'h0000
// Pointer steps for byte and word accesses
`define CDP_STEP_BYTE 16'h0001
`define CDP_STEP_WORD 16'h0002
// Stack pointer step per push or pop
`define CDP_SP_STEP 16'h0002
// Upper byte of an 8-bit pointer field
`define CDP_PTR_HI 8'h00
// Largest decimal digit and its adjust
`define CDP_BCD_MAX 5'h09
`define CDP_BCD_ADJ 4'h6
`define CDP_BCD_NINE 4'h9
// Single bit for bit masks
`define CDP_BIT_ONE 16'h0001
// Position of the byte offset inside the secondary pointer
`define CDP_BIT_POS 3
// Divide by zero quotient
`define CDP_DZ_Q 16'hFFFF
`define CDP_DZ_Q32 32'hFFFF_FFFF
`endif

/* shared/cdp_pkg.sv */
package cdp_pkg;
  typedef enum logic [4:0] {
    add_op, add_carry_op, short_immediate_sum_op, decimal_sum_op,
    difference_with_carry_op, decimal_difference_op, unsigned_product_op,
    quotient_op, double_word_quotient_op, test_equal_op, test_greater_op,
    and_op, or_op, xor_op, plus_one_op, minus_one_skip_zero_op,
    bit_set_op, bit_clear_op, bit_test_op, fetch_op, write_back_op,
    push_op, pop_op, load_primary_op, load_limit_op, load_secondary_op
  } cdp_op_t;
  typedef enum logic [3:0] {
    mode_reg_b, mode_reg_x, mode_direct, mode_indirect, mode_indexed,
    mode_immediate, mode_auto_x, mode_auto_b_skip, mode_mem_mem,
    mode_imm_mem, mode_bit_pair
  } cdp_mode_t;
  typedef enum {st_idle, st_ptr, st_rd, st_rd2, st_exec, st_wr} cdp_state_t;
endpackage

/* logic/cdp_core.sv */
`include "cdp_params.svh"
module cdp_core #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Decoded instruction
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire cdp_pkg::cdp_op_t cmd_op,
  input wire cdp_pkg::cdp_mode_t cmd_mode,
  input wire logic cmd_word,
  input wire logic cmd_down,
  input wire logic [2:0] cmd_len,
  input wire logic [15:0] cmd_fld_a,
  input wire logic [15:0] cmd_fld_b,
  // Memory bus
  output logic mem_req,
  output logic mem_we,
  output logic mem_byte,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // Core state
  output logic done,
  output logic skip_pending,
  output logic carry_flag,
  output logic [15:0] accumulator_reg,
  output logic [15:0] primary_pointer_reg,
  output logic [15:0] secondary_pointer_reg,
  output logic [15:0] loop_limit_reg,
  output logic [15:0] stack_top_pointer_reg,
  output logic [15:0] program_counter_reg
);
  if (DATA_W != 16) begin : g_bad_width
    $error("cdp_core serves a 16-bit datapath only");
  end

  cdp_pkg::cdp_state_t state_q;
  cdp_pkg::cdp_op_t op_q;
  cdp_pkg::cdp_mode_t mode_q;
  logic word_q, down_q;
  logic [15:0] fb_q, ea_q, dadr_q, opnd_q, dval_q;
  logic fire, ptr_in, imm_in, bit_in, nord_in, word_in;
  logic [15:0] ea_in, immv_in, bit_addr, rd_val, ptr_ea;
  logic exec, memdst, auto_x, auto_b, bpass;
  logic [15:0] step, lhs, bop, xnext, bnext, bmask, waddr;
  logic [2:0] bit_sel;

  assign fire = cmd_valid & cmd_ready;
  assign ptr_in = cmd_mode == cdp_pkg::mode_indirect || cmd_mode == cdp_pkg::mode_indexed;
  assign imm_in = cmd_mode == cdp_pkg::mode_immediate;
  assign bit_in = cmd_op == cdp_pkg::bit_set_op || cmd_op == cdp_pkg::bit_clear_op
    || cmd_op == cdp_pkg::bit_test_op;
  assign nord_in = cmd_op == cdp_pkg::write_back_op || cmd_op == cdp_pkg::push_op;
  // Bit ops are byte wide, stack traffic is word wide
  assign word_in = (cmd_word || cmd_op == cdp_pkg::push_op || cmd_op == cdp_pkg::pop_op)
    && !bit_in;
  assign bit_addr = primary_pointer_reg
    + {3'b000, secondary_pointer_reg[15:`CDP_BIT_POS]};
  assign ea_in = cmd_op == cdp_pkg::push_op ? stack_top_pointer_reg
    : cmd_op == cdp_pkg::pop_op ? stack_top_pointer_reg - `CDP_SP_STEP
    : (cmd_mode == cdp_pkg::mode_reg_b || cmd_mode == cdp_pkg::mode_auto_b_skip)
      ? primary_pointer_reg
    : (cmd_mode == cdp_pkg::mode_reg_x || cmd_mode == cdp_pkg::mode_auto_x)
      ? secondary_pointer_reg
    : cmd_mode == cdp_pkg::mode_bit_pair ? bit_addr
    : cmd_mode == cdp_pkg::mode_mem_mem ? cmd_fld_b : cmd_fld_a;
  assign immv_in = (cmd_word && cmd_op != cdp_pkg::short_immediate_sum_op)
    ? cmd_fld_b : {8'h00, cmd_fld_b[7:0]};
  assign rd_val = mem_byte ? {8'h00, mem_rdata[7:0]} : mem_rdata;
  assign ptr_ea = mode_q == cdp_pkg::mode_indexed ? mem_rdata + fb_q : mem_rdata;

  assign exec = state_q == cdp_pkg::st_exec;
  assign memdst = mode_q == cdp_pkg::mode_mem_mem || mode_q == cdp_pkg::mode_imm_mem;
  assign auto_x = mode_q == cdp_pkg::mode_auto_x;
  assign auto_b = mode_q == cdp_pkg::mode_auto_b_skip;
  assign step = word_q ? `CDP_STEP_WORD : `CDP_STEP_BYTE;
  assign xnext = down_q ? secondary_pointer_reg - step : secondary_pointer_reg + step;
  assign bnext = down_q ? primary_pointer_reg - step : primary_pointer_reg + step;
  assign bpass = down_q ? bnext < loop_limit_reg : bnext > loop_limit_reg;
  // accumulator unless memory is the destination
  assign lhs = memdst ? dval_q : accumulator_reg;
  assign bit_sel = mode_q == cdp_pkg::mode_bit_pair
    ? secondary_pointer_reg[2:0] : fb_q[2:0];
  assign bmask = `CDP_BIT_ONE << bit_sel;
  assign waddr = memdst ? dadr_q : ea_q;

  // Binary adder, shared by add and subtract
  logic bsub, cin, bcar;
  logic [16:0] bsum17;
  logic [8:0] bsum9;
  assign bsub = op_q == cdp_pkg::difference_with_carry_op;
  assign cin = (op_q == cdp_pkg::add_carry_op || bsub) ? carry_flag : 1'b0;
  assign bop = bsub ? ~opnd_q : opnd_q;
  assign bsum17 = {1'b0, lhs} + {1'b0, bop} + {16'h0000, cin};
  assign bsum9 = {1'b0, lhs[7:0]} + {1'b0, bop[7:0]} + {8'h00, cin};
  assign bcar = word_q ? bsum17[16] : bsum9[8];

  // Decimal adder; decimal_difference_op adds the nines complement
  logic dsub, dcar;
  logic [4:0] bcd_c;
  logic [15:0] dsum;
  assign dsub = op_q == cdp_pkg::decimal_difference_op;
  assign bcd_c[0] = carry_flag;
  for (genvar gi = 0; gi < DATA_W / 4; gi++) begin : g_bcd
    logic [3:0] nb;
    logic [4:0] t;
    logic ov;
    assign nb = dsub ? `CDP_BCD_NINE - opnd_q[4*gi +: 4] : opnd_q[4*gi +: 4];
    assign t = {1'b0, lhs[4*gi +: 4]} + {1'b0, nb} + {4'h0, bcd_c[gi]};
    assign ov = t > `CDP_BCD_MAX;
    assign dsum[4*gi +: 4] = ov ? t[3:0] + `CDP_BCD_ADJ : t[3:0];
    assign bcd_c[gi+1] = ov;
  end
  // decimal carry from the digit chain
  assign dcar = word_q ? bcd_c[4] : bcd_c[2];

  // Multiply and divide; divide by zero flags carry
  logic dz;
  logic [31:0] prod, div32, q32, r32;
  logic [15:0] q16, r16;
  assign dz = opnd_q == 16'h0000;
  assign prod = {16'h0000, lhs} * {16'h0000, opnd_q};
  assign div32 = {secondary_pointer_reg, lhs};
  assign q16 = dz ? `CDP_DZ_Q : lhs / opnd_q;
  assign r16 = dz ? lhs : lhs % opnd_q;
  assign q32 = dz ? `CDP_DZ_Q32 : div32 / {16'h0000, opnd_q};
  assign r32 = dz ? 32'h0000_0000 : div32 % {16'h0000, opnd_q};

  logic [15:0] res, resm, hi;
  logic c_nx, wr_m, wr_a, skip_t, md, to_dst;
  assign resm = word_q ? res : {8'h00, res[7:0]};
  always_comb
  begin
    res = opnd_q;
    hi = secondary_pointer_reg;
    c_nx = carry_flag;
    skip_t = 1'b0;
    md = 1'b0;
    to_dst = 1'b0;
    wr_m = 1'b0;
    wr_a = 1'b0;
    case (op_q)
      cdp_pkg::add_op, cdp_pkg::add_carry_op, cdp_pkg::short_immediate_sum_op,
      cdp_pkg::difference_with_carry_op:
      begin
        res = bsum17[15:0];
        c_nx = bcar;
        to_dst = 1'b1;
      end
      cdp_pkg::decimal_sum_op, cdp_pkg::decimal_difference_op:
      begin
        res = dsum;
        c_nx = dcar;
        to_dst = 1'b1;
      end
      cdp_pkg::unsigned_product_op:
      begin
        res = prod[15:0];
        hi = prod[31:16];
        c_nx = 1'b0;
        md = 1'b1;
        wr_a = 1'b1;
      end
      cdp_pkg::quotient_op:
      begin
        res = q16;
        hi = r16;
        c_nx = dz;
        md = 1'b1;
        wr_a = 1'b1;
      end
      cdp_pkg::double_word_quotient_op:
      begin
        res = q32[15:0];
        hi = r32[15:0];
        c_nx = dz || q32[31:16] != 16'h0000;
        md = 1'b1;
        wr_a = 1'b1;
      end
      cdp_pkg::test_equal_op: skip_t = lhs != opnd_q;
      cdp_pkg::test_greater_op: skip_t = !(lhs > opnd_q);
      cdp_pkg::and_op:
      begin
        res = lhs & opnd_q;
        to_dst = 1'b1;
      end
      cdp_pkg::or_op:
      begin
        res = lhs | opnd_q;
        to_dst = 1'b1;
      end
      cdp_pkg::xor_op:
      begin
        res = lhs ^ opnd_q;
        to_dst = 1'b1;
      end
      cdp_pkg::plus_one_op:
      begin
        res = opnd_q + `CDP_STEP_BYTE;
        wr_m = 1'b1;
      end
      cdp_pkg::minus_one_skip_zero_op:
      begin
        res = opnd_q - `CDP_STEP_BYTE;
        wr_m = 1'b1;
        skip_t = resm == 16'h0000;
      end
      cdp_pkg::bit_set_op:
      begin
        res = opnd_q | bmask;
        wr_m = 1'b1;
      end
      cdp_pkg::bit_clear_op:
      begin
        res = opnd_q & ~bmask;
        wr_m = 1'b1;
      end
      cdp_pkg::bit_test_op: skip_t = (opnd_q & bmask) == 16'h0000;
      // fetch also moves immediates to memory
      cdp_pkg::fetch_op: to_dst = 1'b1;
      cdp_pkg::write_back_op, cdp_pkg::push_op:
      begin
        res = accumulator_reg;
        wr_m = 1'b1;
      end
      cdp_pkg::pop_op: wr_a = 1'b1;
      default: res = opnd_q;
    endcase
    if (to_dst)
    begin
      wr_a = !memdst;
      wr_m = memdst;
    end
  end

  // Sequencer and memory bus
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= cdp_pkg::st_idle;
      cmd_ready <= 1'b1;
      done <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_byte <= 1'b0;
      mem_addr <= `CDP_REG_RST;
      mem_wdata <= `CDP_REG_RST;
      op_q <= cdp_pkg::fetch_op;
      mode_q <= cdp_pkg::mode_immediate;
      word_q <= 1'b0;
      down_q <= 1'b0;
      fb_q <= `CDP_REG_RST;
      ea_q <= `CDP_REG_RST;
      dadr_q <= `CDP_REG_RST;
      opnd_q <= `CDP_REG_RST;
      dval_q <= `CDP_REG_RST;
    end
    else
    begin
      done <= 1'b0;
      case (state_q)
        cdp_pkg::st_idle:
          if (fire && skip_pending)
            done <= 1'b1;
          else if (fire)
          begin
            op_q <= cmd_op;
            mode_q <= cmd_mode;
            word_q <= word_in;
            down_q <= cmd_down;
            fb_q <= cmd_fld_b;
            ea_q <= ea_in;
            dadr_q <= cmd_fld_a;
            opnd_q <= immv_in;
            cmd_ready <= 1'b0;
            if (ptr_in)
            begin
              state_q <= cdp_pkg::st_ptr;
              mem_req <= 1'b1;
              mem_byte <= 1'b0;
              mem_addr <= {`CDP_PTR_HI, cmd_fld_a[7:0]};
            end
            else if (cmd_mode == cdp_pkg::mode_imm_mem)
            begin
              state_q <= cdp_pkg::st_rd2;
              mem_req <= 1'b1;
              mem_byte <= !word_in;
              mem_addr <= cmd_fld_a;
            end
            else if (imm_in || nord_in)
              state_q <= cdp_pkg::st_exec;
            else
            begin
              state_q <= cdp_pkg::st_rd;
              mem_req <= 1'b1;
              mem_byte <= !word_in;
              mem_addr <= ea_in;
            end
          end
        cdp_pkg::st_ptr:
          if (mem_ack)
          begin
            ea_q <= ptr_ea;
            mem_addr <= ptr_ea;
            mem_byte <= !word_q;
            state_q <= cdp_pkg::st_rd;
          end
        cdp_pkg::st_rd:
          if (mem_ack)
          begin
            opnd_q <= rd_val;
            if (mode_q == cdp_pkg::mode_mem_mem)
            begin
              mem_addr <= dadr_q;
              state_q <= cdp_pkg::st_rd2;
            end
            else
            begin
              mem_req <= 1'b0;
              state_q <= cdp_pkg::st_exec;
            end
          end
        cdp_pkg::st_rd2:
          if (mem_ack)
          begin
            dval_q <= rd_val;
            mem_req <= 1'b0;
            state_q <= cdp_pkg::st_exec;
          end
        cdp_pkg::st_exec:
          if (wr_m)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_byte <= !word_q;
            mem_addr <= waddr;
            mem_wdata <= resm;
            state_q <= cdp_pkg::st_wr;
          end
          else
          begin
            done <= 1'b1;
            cmd_ready <= 1'b1;
            state_q <= cdp_pkg::st_idle;
          end
        cdp_pkg::st_wr:
          if (mem_ack)
          begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            done <= 1'b1;
            cmd_ready <= 1'b1;
            state_q <= cdp_pkg::st_idle;
          end
        default: state_q <= cdp_pkg::st_idle;
      endcase
    end
  end

  // Architectural registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      skip_pending <= 1'b0;
      carry_flag <= 1'b0;
      accumulator_reg <= `CDP_REG_RST;
      primary_pointer_reg <= `CDP_REG_RST;
      secondary_pointer_reg <= `CDP_REG_RST;
      loop_limit_reg <= `CDP_REG_RST;
      stack_top_pointer_reg <= `CDP_SP_RST;
      program_counter_reg <= `CDP_REG_RST;
    end
    else
    begin
      if (fire)
        program_counter_reg <= program_counter_reg + {13'h0000, cmd_len};
      // skip consumed by the next instruction
      if (fire && skip_pending)
        skip_pending <= 1'b0;
      if (exec)
      begin
        carry_flag <= c_nx;
        if (wr_a)
          accumulator_reg <= resm;
        if (auto_x)
          secondary_pointer_reg <= xnext;
        if (auto_b)
          primary_pointer_reg <= bnext;
        // limit cleared, mul/div wins over stepping
        if (md)
        begin
          secondary_pointer_reg <= hi;
          loop_limit_reg <= `CDP_REG_RST;
        end
        if (skip_t || (auto_b && bpass))
          skip_pending <= 1'b1;
        if (op_q == cdp_pkg::push_op)
          stack_top_pointer_reg <= stack_top_pointer_reg + `CDP_SP_STEP;
        if (op_q == cdp_pkg::pop_op)
          stack_top_pointer_reg <= stack_top_pointer_reg - `CDP_SP_STEP;
        if (op_q == cdp_pkg::load_primary_op)
          primary_pointer_reg <= opnd_q;
        if (op_q == cdp_pkg::load_limit_op)
          loop_limit_reg <= opnd_q;
        if (op_q == cdp_pkg::load_secondary_op)
          secondary_pointer_reg <= opnd_q;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sp_step_a: assert property (
    $changed(stack_top_pointer_reg) |->
      (stack_top_pointer_reg - $past(stack_top_pointer_reg) == 16'h0002)
      || (stack_top_pointer_reg - $past(stack_top_pointer_reg) == 16'hFFFE))
    else $error("stack pointer moved by other than two");
  skip_drop_a: assert property (
    fire && skip_pending |=> $stable(accumulator_reg) && $stable(primary_pointer_reg)
      && $stable(secondary_pointer_reg) && $stable(loop_limit_reg)
      && !mem_req && !skip_pending && state_q == cdp_pkg::st_idle)
    else $error("discarded instruction changed state");
  exec_once_a: assert property (
    exec |=> state_q != cdp_pkg::st_exec)
    else $error("execute lasted more than one cycle");
  prod_split_a: assert property (
    exec && op_q == cdp_pkg::unsigned_product_op |=> loop_limit_reg == 16'h0000
      && {secondary_pointer_reg, accumulator_reg} == $past(lhs) * $past(opnd_q))
    else $error("product not split into accumulator and secondary");
  add_carry_a: assert property (
    exec && op_q == cdp_pkg::add_op && word_q && !memdst |=>
      {carry_flag, accumulator_reg} == $past(accumulator_reg) + $past(opnd_q))
    else $error("add sum or carry wrong");
  bit_addr_a: assert property (
    $rose(mem_req) && state_q == cdp_pkg::st_rd && mode_q == cdp_pkg::mode_bit_pair
      |-> mem_byte && mem_addr == primary_pointer_reg + (secondary_pointer_reg >> 3))
    else $error("pair bit address wrong");
  auto_x_a: assert property (
    exec && auto_x && !md |=> secondary_pointer_reg == ($past(down_q)
      ? $past(secondary_pointer_reg) - $past(step)
      : $past(secondary_pointer_reg) + $past(step)))
    else $error("secondary pointer step wrong");
  and_res_a: assert property (
    exec && op_q == cdp_pkg::and_op && word_q && !memdst |=>
      accumulator_reg == ($past(accumulator_reg) & $past(opnd_q)))
    else $error("and result wrong");
  dec_skip_a: assert property (
    exec && op_q == cdp_pkg::minus_one_skip_zero_op && opnd_q == 16'h0001
      |=> skip_pending ##1 mem_req && mem_wdata == 16'h0000)
    else $error("decrement to zero did not skip");
  mem_hold_a: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request dropped before acknowledge");

  skip_seen_c: cover property (fire && skip_pending);
  double_word_quotient_op_seen_c: cover property (exec && op_q == cdp_pkg::double_word_quotient_op);
  limit_pass_c: cover property (exec && auto_b && bpass);
  bit_fail_c: cover property (exec && op_q == cdp_pkg::bit_test_op && skip_t);
endmodule // cdp_core

/* test/cdp_mem_model.sv */
module cdp_mem_model (
  // Clock
  input wire logic clk,
  // Core memory bus
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_byte,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  // Answer pace
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:65535];
  int wait_cnt = 0;
  logic r, w, b, k;
  logic [15:0] a, d;
  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
    mem_ack = 1'b0;
    mem_rdata = 16'h5a5a;
  end
  always @(posedge clk)
  begin
    r = mem_req;
    w = mem_we;
    b = mem_byte;
    k = mem_ack;
    a = mem_addr;
    d = mem_wdata;
    #1;
    mem_ack = 1'b0;
    // Stale data is scrambled so a late sample cannot pass
    mem_rdata = ~mem_rdata;
    if (r && !k)
    begin
      if (wait_cnt < (slow ? 2 : 0))
        wait_cnt++;
      else
      begin
        wait_cnt = 0;
        mem_ack = 1'b1;
        if (w)
        begin
          mem[a] = d[7:0];
          if (!b)
            mem[a + 16'h0001] = d[15:8];
        end
        else
          mem_rdata = b ? {~mem[a], mem[a]} : {mem[a + 16'h0001], mem[a]};
      end
    end
  end
endmodule // cdp_mem_model

/* test/tb_cpu16_datapath_addressing.sv */
module tb_cpu16_datapath_addressing;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, srst, cmd_valid, cmd_ready, cmd_word, cmd_down, slow;
  cdp_pkg::cdp_op_t cmd_op;
  cdp_pkg::cdp_mode_t cmd_mode;
  logic [2:0] cmd_len;
  logic [15:0] cmd_fld_a, cmd_fld_b, mem_addr, mem_wdata, mem_rdata, acc, b_reg, x_reg, k_reg;
  logic [15:0] sp_reg, pc_reg, exp_pc, exp_acc, v;
  logic mem_req, mem_we, mem_byte, mem_ack, done, skip_pending, carry_flag, exp_c;
  int err_total = 0;
  int n_checks = 0;
  int seed = 32'h8dc7;
  cdp_pkg::cdp_op_t ops [7] = '{cdp_pkg::add_op, cdp_pkg::add_carry_op, cdp_pkg::and_op,
    cdp_pkg::difference_with_carry_op, cdp_pkg::or_op, cdp_pkg::xor_op, cdp_pkg::fetch_op};
  cdp_core DUT (.clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_mode(cmd_mode), .cmd_word(cmd_word), .cmd_down(cmd_down),
    .cmd_len(cmd_len), .cmd_fld_a(cmd_fld_a), .cmd_fld_b(cmd_fld_b), .mem_req(mem_req),
    .mem_we(mem_we), .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .done(done), .skip_pending(skip_pending),
    .carry_flag(carry_flag), .accumulator_reg(acc), .primary_pointer_reg(b_reg),
    .secondary_pointer_reg(x_reg), .loop_limit_reg(k_reg), .stack_top_pointer_reg(sp_reg),
    .program_counter_reg(pc_reg));
  cdp_mem_model u_mem (.clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_byte(mem_byte),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .slow(slow));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task results;
    if (err_total == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task sk(input logic e);
    chk({15'h0000, skip_pending}, {15'h0000, e});
  endtask
  function logic [15:0] mw(input logic [15:0] a);
    return {u_mem.mem[a + 16'h0001], u_mem.mem[a]};
  endfunction
  function logic [16:0] alu(input cdp_pkg::cdp_op_t op, input logic [15:0] a, input logic [15:0] b,
    input logic c);
    case (op)
      cdp_pkg::add_op: return {1'b0, a} + {1'b0, b};
      cdp_pkg::add_carry_op: return {1'b0, a} + {1'b0, b} + {16'h0000, c};
      cdp_pkg::difference_with_carry_op: return {1'b0, a} + {1'b0, ~b} + {16'h0000, c};
      cdp_pkg::and_op: return {c, a & b};
      cdp_pkg::or_op: return {c, a | b};
      cdp_pkg::xor_op: return {c, a ^ b};
      default: return {c, b};
    endcase
  endfunction
  task run(input cdp_pkg::cdp_op_t op, input cdp_pkg::cdp_mode_t md, input logic wd,
    input logic dn, input logic [15:0] fa, input logic [15:0] fb);
    int i;
    cmd_op = op;
    cmd_mode = md;
    cmd_word = wd;
    cmd_down = dn;
    cmd_fld_a = fa;
    cmd_fld_b = fb;
    cmd_len = 3'($random(seed));
    cmd_valid = 1'b1;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    exp_pc = exp_pc + {13'h0000, cmd_len};
    for (i = 0; i < 60 && done !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    // A run that never completes counts as a mismatch here
    chk({15'h0000, done}, 16'h0001);
    chk(pc_reg, exp_pc);
  endtask
  // Next instruction must leave no trace but the program counter
  task dsc;
    v = acc;
    run(cdp_pkg::fetch_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, ~v);
    chk(acc, v);
    sk(1'b0);
  endtask
  initial
  begin
    #100000;
    err_total++;
    results;
  end
  initial
  begin
    srst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = cdp_pkg::fetch_op;
    cmd_mode = cdp_pkg::mode_immediate;
    {cmd_word, cmd_down, slow} = 3'b100;
    cmd_len = 3'h2;
    cmd_fld_a = 16'h0000;
    cmd_fld_b = 16'h0000;
    exp_pc = 16'h0000;
    {exp_c, exp_acc} = 17'h0_0000;
    repeat (4) @(posedge clk);
    #1;
    srst = 1'b0;
    chk(acc | b_reg | x_reg | k_reg | sp_reg | pc_reg, 16'h0000);
    chk({13'h0000, carry_flag, cmd_ready, skip_pending}, 16'h0002);
    for (int n = 0; n < 40; n++)
    begin
      cmd_op = ops[$unsigned($random(seed)) % 7];
      v = 16'($random(seed));
      {exp_c, exp_acc} = alu(cmd_op, exp_acc, v, exp_c);
      run(cmd_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, v);
      chk(acc, exp_acc);
      chk({15'h0000, carry_flag}, {15'h0000, exp_c});
    end
    slow = 1'b1;
    u_mem.mem[16'h0040] = 8'h34;
    u_mem.mem[16'h0041] = 8'h12;
    {exp_c, exp_acc} = {1'b0, exp_acc} + 17'h0_1234;
    run(cdp_pkg::add_op, cdp_pkg::mode_direct, 1'b1, 1'b0, 16'h0040, 16'h0000);
    chk(acc, exp_acc);
    run(cdp_pkg::fetch_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, 16'h1234);
    run(cdp_pkg::unsigned_product_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, 16'h0100);
    chk(acc, 16'h3400);
    chk(x_reg | k_reg | {15'h0000, carry_flag}, 16'h0012);
    run(cdp_pkg::load_primary_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, 16'h0100);
    run(cdp_pkg::load_limit_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, 16'h0102);
    {u_mem.mem[16'h0100], u_mem.mem[16'h0101]} = 16'h1122;
    {u_mem.mem[16'h0102], u_mem.mem[16'h0103]} = 16'h3344;
    run(cdp_pkg::fetch_op, cdp_pkg::mode_auto_b_skip, 1'b1, 1'b0, 16'h0000, 16'h0000);
    chk(acc ^ b_reg, 16'h2211 ^ 16'h0102);
    sk(1'b0);
    run(cdp_pkg::fetch_op, cdp_pkg::mode_auto_b_skip, 1'b1, 1'b0, 16'h0000, 16'h0000);
    chk(b_reg, 16'h0104);
    sk(1'b1);
    dsc;
    run(cdp_pkg::load_primary_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, 16'h0103);
    run(cdp_pkg::fetch_op, cdp_pkg::mode_auto_b_skip, 1'b0, 1'b1, 16'h0000, 16'h0000);
    chk(acc ^ b_reg, 16'h0044 ^ 16'h0102);
    sk(1'b0);
    run(cdp_pkg::fetch_op, cdp_pkg::mode_auto_b_skip, 1'b0, 1'b1, 16'h0000, 16'h0000);
    sk(1'b1);
    dsc;
    run(cdp_pkg::load_secondary_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, 16'h0101);
    run(cdp_pkg::fetch_op, cdp_pkg::mode_auto_x, 1'b0, 1'b1, 16'h0000, 16'h0000);
    chk(acc ^ x_reg, 16'h0022 ^ 16'h0100);
    run(cdp_pkg::fetch_op, cdp_pkg::mode_auto_x, 1'b1, 1'b0, 16'h0000, 16'h0000);
    chk(acc ^ x_reg, 16'h2211 ^ 16'h0102);
    run(cdp_pkg::fetch_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, 16'hbeef);
    run(cdp_pkg::push_op, cdp_pkg::mode_reg_b, 1'b1, 1'b0, 16'h0000, 16'h0000);
    chk(mw(16'h0000) ^ sp_reg, 16'hbeef ^ 16'h0002);
    run(cdp_pkg::fetch_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, 16'h0000);
    run(cdp_pkg::pop_op, cdp_pkg::mode_reg_b, 1'b1, 1'b0, 16'h0000, 16'h0000);
    chk(acc ^ sp_reg, 16'hbeef);
    run(cdp_pkg::load_primary_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, 16'h0300);
    run(cdp_pkg::load_secondary_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, 16'h0015);
    run(cdp_pkg::bit_set_op, cdp_pkg::mode_bit_pair, 1'b0, 1'b0, 16'h0000, 16'h0000);
    chk(mw(16'h0302), 16'h0020);
    run(cdp_pkg::bit_test_op, cdp_pkg::mode_bit_pair, 1'b0, 1'b0, 16'h0000, 16'h0000);
    sk(1'b0);
    run(cdp_pkg::bit_clear_op, cdp_pkg::mode_bit_pair, 1'b0, 1'b0, 16'h0000, 16'h0000);
    chk(mw(16'h0302), 16'h0000);
    run(cdp_pkg::bit_test_op, cdp_pkg::mode_bit_pair, 1'b0, 1'b0, 16'h0000, 16'h0000);
    sk(1'b1);
    dsc;
    u_mem.mem[16'h0050] = 8'h02;
    for (int n = 1; n >= 0; n--)
    begin
      run(cdp_pkg::minus_one_skip_zero_op, cdp_pkg::mode_direct, 1'b0, 1'b0, 16'h0050, 16'h0000);
      chk({8'h00, u_mem.mem[16'h0050]}, 16'(n));
      sk(n == 0);
    end
    dsc;
    v = acc;
    run(cdp_pkg::test_equal_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, v);
    sk(1'b0);
    run(cdp_pkg::test_equal_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, ~v);
    sk(1'b1);
    dsc;
    run(cdp_pkg::test_greater_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, v);
    sk(1'b1);
    dsc;
    run(cdp_pkg::fetch_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, 16'h9999);
    run(cdp_pkg::decimal_sum_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, 16'h0001);
    chk(acc ^ {15'h0000, carry_flag}, 16'h0001);
    run(cdp_pkg::decimal_difference_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, 16'h0001);
    chk(acc ^ {15'h0000, carry_flag}, 16'h9999);
    run(cdp_pkg::short_immediate_sum_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, 16'hff01);
    chk(acc, 16'h999a);
    run(cdp_pkg::quotient_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, 16'h0010);
    chk(acc ^ x_reg, 16'h0999 ^ 16'h000a);
    chk(k_reg | {15'h0000, carry_flag}, 16'h0000);
    run(cdp_pkg::double_word_quotient_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, 16'h0100);
    chk(acc ^ x_reg, 16'h0a09 ^ 16'h0099);
    run(cdp_pkg::fetch_op, cdp_pkg::mode_imm_mem, 1'b1, 1'b0, 16'h0300, 16'h5a3c);
    chk(mw(16'h0300), 16'h5a3c);
    run(cdp_pkg::fetch_op, cdp_pkg::mode_reg_b, 1'b1, 1'b0, 16'h0000, 16'h0000);
    chk(acc, 16'h5a3c);
    run(cdp_pkg::add_op, cdp_pkg::mode_mem_mem, 1'b1, 1'b0, 16'h0300, 16'h0100);
    chk(mw(16'h0300), 16'h7c4d);
    run(cdp_pkg::load_secondary_op, cdp_pkg::mode_immediate, 1'b1, 1'b0, 16'h0000, 16'h0300);
    run(cdp_pkg::fetch_op, cdp_pkg::mode_reg_x, 1'b1, 1'b0, 16'h0000, 16'h0000);
    chk(acc, 16'h7c4d);
    {u_mem.mem[16'h0061], u_mem.mem[16'h0060]} = 16'h0100;
    run(cdp_pkg::fetch_op, cdp_pkg::mode_indirect, 1'b1, 1'b0, 16'hff60, 16'h0000);
    chk(acc, 16'h2211);
    run(cdp_pkg::fetch_op, cdp_pkg::mode_indexed, 1'b1, 1'b0, 16'h0060, 16'h0002);
    chk(acc, 16'h4433);
    run(cdp_pkg::plus_one_op, cdp_pkg::mode_direct, 1'b0, 1'b0, 16'h0050, 16'h0000);
    chk({8'h00, u_mem.mem[16'h0050]}, 16'h0001);
    results;
  end
endmodule // tb_cpu16_datapath_addressing
